/* File: pin_ctrl_pkg.sv */
// Constants, register map and carrier types for the pin control block
// Functional notes
// (RULE_01) Bit 15 direction; input resets; codes 0/1 GPIO
// (RULE_02) Bits 14:13 pull; resets to pull-down
// (RULE_03) Mode 0: edge follows polarity
// (RULE_04) Mode 1: interrupt on both edges
// (RULE_05) Bit 10 polarity, 1 active high
// (RULE_06) Bit 9 selects push-pull or open-drain
// (RULE_07) Bit 7 enable; 0 keeps pin tri-stated
// (RULE_08) Input codes 2-6 power and sleep requests
// (RULE_09) Codes 7-9 watchdog and voltage-scale selects
// (RULE_10) Codes 10-15 hardware enable and control inputs
// (RULE_11) Output code 0 level, 1 slow clock
// (RULE_12) Codes 2-4 state outputs, 5-7 reserved
// (RULE_13) Codes 8-11 scaling done, power enables
// (RULE_14) Codes 12-15 supply good, 2MHz, reset
// (RULE_15) Second pin register identical layout and defaults
// (RULE_16) Synchronised, debounced, one interrupt per edge; code debounces only input codes 0, 4, 14 and 15, others pass synchronised only
package pin_ctrl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] PIN1_CONTROL_IDX = 16'h4038;
    localparam logic [15:0] PIN2_CONTROL_IDX = 16'h4039;
    localparam logic [15:0] IRQ_STATUS_IDX = 16'h4080;
    localparam logic [15:0] IRQ_MASK_IDX = 16'h4081;
    localparam logic [15:0] PIN_LEVEL_IDX = 16'h4082;
    localparam logic [15:0] OUT_LEVEL_IDX = 16'h4083;

    localparam logic [15:0] PIN_CONTROL_RESET = 16'hA400;
    localparam logic [15:0] PIN_CONTROL_WMASK = 16'hFE8F;
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;

    localparam int CLOCK_MHZ = 100;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int LONG_DEBOUNCE_US = 10000;
    localparam int LONG_DEBOUNCE_CYCLES = LONG_DEBOUNCE_US * CLOCK_MHZ;
    localparam int CLK2M_HALF_NS = 250;
    localparam int CLK2M_HALF_CYCLES = CLK2M_HALF_NS / CLOCK_PERIOD_NS;

    typedef struct packed {
        logic direction;
        logic [1:0] pull_select;
        logic irq_edge_mode;
        logic pin_supply_select;
        logic pin_polarity;
        logic open_drain_select;
        logic reserved_8;
        logic pin_enable;
        logic [2:0] reserved_6_4;
        logic [3:0] pin_function;
    } pin_ctrl_t;

    typedef struct packed {
        logic power_onoff_req;
        logic sleep_wake_req;
        logic sleep_req;
        logic power_on_req;
        logic watchdog_reset;
        logic voltage_scale_sel_one;
        logic voltage_scale_sel_two;
        logic [1:0] hw_enable;
        logic [1:0] hw_control;
    } pin_requests_t;

    typedef struct packed {
        logic on_state;
        logic sleep_state;
        logic power_state_change;
        logic [1:0] dvs_done;
        logic [1:0] ext_power_enable;
        logic system_supply_good;
        logic converter_power_good;
        logic aux_reset;
    } status_src_t;

endpackage

/* File: gpio_pin_control.sv */
// Two configurable general-purpose pins with Avalon-MM registers and interrupt
`timescale 1ns/1ps
`default_nettype none

module pin_cell
    import pin_ctrl_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = LONG_DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Configuration and sources
    input wire pin_ctrl_t ctrl,
    input wire logic out_level,
    input wire status_src_t sources,
    input wire logic clk32k,
    input wire logic clk2m,
    // Pad
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic pull_up_en,
    output logic pull_down_en,
    // Observed state
    output logic active_level,
    output logic irq_event
);

    logic sync0;
    logic sync1;
    logic filtered;
    logic prev_raw;
    logic [23:0] stable_count;
    logic long_sel;
    logic raw;
    logic listening;
    logic rise;
    logic fall;
    logic src;
    logic drive;

    ////////////////////////////////////////////////////////////////////////
    // Input path

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync0 <= 1'b0;
            sync1 <= 1'b0;
        end else begin
            sync0 <= pin_in; // RULE_16
            sync1 <= sync0;
        end
    end

    // Level must hold unchanged for the full window before it is accepted
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            filtered <= 1'b0;
            stable_count <= 24'h00_0000;
        end else if (sync1 == filtered) begin
            stable_count <= 24'h00_0000;
        end else if (stable_count == 24'(DEBOUNCE_CYCLES - 1)) begin
            filtered <= sync1; // RULE_16
            stable_count <= 24'h00_0000;
        end else begin
            stable_count <= stable_count + 24'h00_0001;
        end
    end

    always_comb begin
        case (ctrl.pin_function)
            4'h0, 4'h4, 4'hE, 4'hF: long_sel = 1'b1; // RULE_01 RULE_08 RULE_10
            default: long_sel = 1'b0;
        endcase
    end

    assign raw = long_sel ? filtered : sync1;
    assign listening = ctrl.pin_enable & ctrl.direction; // RULE_01 RULE_07
    assign rise = raw & ~prev_raw;
    assign fall = ~raw & prev_raw;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_raw <= 1'b0;
            irq_event <= 1'b0;
            active_level <= 1'b0;
        end else begin
            prev_raw <= raw;
            if (!listening) begin
                irq_event <= 1'b0;
            end else if (ctrl.irq_edge_mode) begin
                irq_event <= rise | fall; // RULE_04
            end else begin
                irq_event <= ctrl.pin_polarity ? rise : fall; // RULE_03
            end
            active_level <= listening & (ctrl.pin_polarity ? raw : ~raw); // RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output path

    always_comb begin
        case (ctrl.pin_function)
            4'h0: src = out_level; // RULE_11
            4'h1: src = clk32k; // RULE_11
            4'h2: src = sources.on_state; // RULE_12
            4'h3: src = sources.sleep_state; // RULE_12
            4'h4: src = sources.power_state_change; // RULE_12
            4'h8: src = sources.dvs_done[0]; // RULE_13
            4'h9: src = sources.dvs_done[1]; // RULE_13
            4'hA: src = sources.ext_power_enable[0]; // RULE_13
            4'hB: src = sources.ext_power_enable[1]; // RULE_13
            4'hC: src = sources.system_supply_good; // RULE_14
            4'hD: src = sources.converter_power_good; // RULE_14
            4'hE: src = clk2m; // RULE_14
            4'hF: src = sources.aux_reset; // RULE_14
            default: src = 1'b0; // RULE_12
        endcase
    end

    assign drive = ctrl.pin_polarity ? src : ~src; // RULE_05

    // Open drain only ever pulls low; a high level is left to the pull-up
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
            pull_up_en <= 1'b0;
            pull_down_en <= 1'b1;
        end else begin
            pin_out <= ctrl.open_drain_select ? 1'b0 : drive; // RULE_06
            pin_oe_n <= ~(ctrl.pin_enable & ~ctrl.direction
                          & (~ctrl.open_drain_select | ~drive)); // RULE_06 RULE_07 RULE_01
            pull_up_en <= (ctrl.pull_select == PULL_UP); // RULE_02
            pull_down_en <= (ctrl.pull_select == PULL_DOWN); // RULE_02
        end
    end

endmodule

module gpio_pin_control
    import pin_ctrl_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = LONG_DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [17:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    // Pads
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe_n,
    output logic [1:0] pull_up_en,
    output logic [1:0] pull_down_en,
    // System side
    input wire logic osc_32k,
    input wire status_src_t sources,
    output pin_requests_t requests
);

    logic rst_meta;
    logic rst_n;
    logic osc_meta;
    logic osc_sync;
    logic [4:0] div_count;
    logic clk2m;
    pin_ctrl_t pin_control [2];
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] out_level;
    logic [1:0] active_level;
    logic [1:0] irq_event;
    logic [15:0] word_index;
    logic accept;
    logic [15:0] wmask;
    logic [31:0] next_readdata;
    logic [1:0] next_status;
    pin_requests_t next_requests;

    ////////////////////////////////////////////////////////////////////////
    // Reset, slow clock and divider

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
        end else begin
            osc_meta <= osc_32k;
            osc_sync <= osc_meta;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_count <= 5'h00;
            clk2m <= 1'b0;
        end else if (div_count == 5'(CLK2M_HALF_CYCLES - 1)) begin
            div_count <= 5'h00;
            clk2m <= ~clk2m; // RULE_14
        end else begin
            div_count <= div_count + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then answer

    assign word_index = address[17:2];
    assign accept = (read | write) & ~waitrequest;
    assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}} & PIN_CONTROL_WMASK;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else if (!waitrequest) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~(read | write);
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (word_index)
            PIN1_CONTROL_IDX: next_readdata[15:0] = pin_control[0] & PIN_CONTROL_WMASK;
            PIN2_CONTROL_IDX: next_readdata[15:0] = pin_control[1] & PIN_CONTROL_WMASK;
            IRQ_STATUS_IDX: next_readdata[1:0] = irq_status;
            IRQ_MASK_IDX: next_readdata[1:0] = irq_mask;
            PIN_LEVEL_IDX: next_readdata[1:0] = active_level;
            OUT_LEVEL_IDX: next_readdata[1:0] = out_level;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read & waitrequest) begin
            readdata <= next_readdata;
        end
    end

    // Both pins share one layout and reset value
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_control[0] <= PIN_CONTROL_RESET; // RULE_01 RULE_02 RULE_05
            pin_control[1] <= PIN_CONTROL_RESET; // RULE_15
        end else if (accept & write) begin
            if (word_index == PIN1_CONTROL_IDX) begin
                pin_control[0] <= (pin_control[0] & ~wmask) | (writedata[15:0] & wmask);
            end
            if (word_index == PIN2_CONTROL_IDX) begin
                pin_control[1] <= (pin_control[1] & ~wmask) | (writedata[15:0] & wmask);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= 2'h0;
            out_level <= 2'h0;
        end else if (accept & write & byteenable[0]) begin
            if (word_index == IRQ_MASK_IDX) begin
                irq_mask <= writedata[1:0];
            end
            if (word_index == OUT_LEVEL_IDX) begin
                out_level <= writedata[1:0]; // RULE_11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: clear on read, a new event in that cycle survives

    always_comb begin
        next_status = irq_status;
        if (accept & read & (word_index == IRQ_STATUS_IDX)) begin
            next_status = 2'h0;
        end
        next_status = next_status | irq_event; // RULE_16
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= 2'h0;
            irq <= 1'b0;
        end else begin
            irq_status <= next_status;
            irq <= |(next_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins and request routing

    for (genvar i = 0; i < 2; i++) begin : g_pin
        pin_cell #(
            .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
        ) u_pin (
            .clock(clock),
            .rst_n(rst_n),
            .ctrl(pin_control[i]),
            .out_level(out_level[i]),
            .sources(sources),
            .clk32k(osc_sync),
            .clk2m(clk2m),
            .pin_in(pin_in[i]),
            .pin_out(pin_out[i]),
            .pin_oe_n(pin_oe_n[i]),
            .pull_up_en(pull_up_en[i]),
            .pull_down_en(pull_down_en[i]),
            .active_level(active_level[i]),
            .irq_event(irq_event[i])
        );
    end

    // Both pins may claim the same request; the requests are ORed
    always_comb begin
        next_requests = '0;
        for (int i = 0; i < 2; i++) begin
            case (pin_control[i].pin_function)
                4'h2: next_requests.power_onoff_req |= active_level[i]; // RULE_08
                4'h3, 4'h4: next_requests.sleep_wake_req |= active_level[i]; // RULE_08
                4'h5: next_requests.sleep_req |= active_level[i]; // RULE_08
                4'h6: next_requests.power_on_req |= active_level[i]; // RULE_08
                4'h7: next_requests.watchdog_reset |= active_level[i]; // RULE_09
                4'h8: next_requests.voltage_scale_sel_one |= active_level[i]; // RULE_09
                4'h9: next_requests.voltage_scale_sel_two |= active_level[i]; // RULE_09
                4'hA: next_requests.hw_enable[0] |= active_level[i]; // RULE_10
                4'hB: next_requests.hw_enable[1] |= active_level[i]; // RULE_10
                4'hC, 4'hE: next_requests.hw_control[0] |= active_level[i]; // RULE_10
                4'hD, 4'hF: next_requests.hw_control[1] |= active_level[i]; // RULE_10
                default: next_requests.power_onoff_req |= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            requests <= '0;
        end else begin
            requests <= next_requests;
        end
    end

endmodule

`default_nettype wire

/* File: pin_ctrl_monitor.sv */
// Bus, pad and interrupt checks for the pin control block
`timescale 1ns/1ps
`default_nettype none
module pin_ctrl_monitor
    import pin_ctrl_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Register bus
    input wire logic [17:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic irq,
    // Pads and system side
    input wire logic [1:0] pin_in,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    input wire logic [1:0] pull_up_en,
    input wire logic [1:0] pull_down_en,
    input wire logic osc_32k,
    input wire status_src_t sources,
    input wire pin_requests_t requests
);
    logic ans;
    logic wr1;
    logic [15:0] wd;
    logic [1:0] prev_pin;
    int quiet;
    assign ans = !waitrequest && (read || write);
    assign wr1 = ans && write && address[17:2] == PIN1_CONTROL_IDX && byteenable[1:0] == 2'b11;
    // Cycles since a pad change or a write; an irq needs a recent cause
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            quiet <= 0;
            prev_pin <= 2'b00;
            wd <= 16'h0000;
        end else begin
            prev_pin <= pin_in;
            quiet <= (pin_in != prev_pin || (ans && write)) ? 0 : quiet + 1;
            if (ans && write) begin
                wd <= writedata[15:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer one cycle after request");
    AST_WAIT_PULSE: assert property (!waitrequest |=> waitrequest)
        else $error("answer held two cycles");
    AST_RSVD_ZERO: assert property (ans && read && address[17:3] == PIN1_CONTROL_IDX[15:1]
        |-> readdata[31:16] == 16'h0000 && !readdata[8] && readdata[6:4] == 3'h0)
        else $error("reserved control bits nonzero");
    AST_RESET_PADS: assert property ($rose(reset_n) |-> pin_oe_n == 2'b11
        && pull_down_en == 2'b11 && pull_up_en == 2'b00 && requests == '0 && !irq)
        else $error("pads not safe after reset");
    AST_PULL_MAP: assert property (wr1 |-> ##2 pull_up_en[0] == (wd[14:13] == 2'b10)
        && pull_down_en[0] == (wd[14:13] == 2'b01))
        else $error("pull enables disagree with field");
    AST_OFF_TRISTATE: assert property (wr1 && (!writedata[7] || writedata[15])
        |-> ##2 pin_oe_n[0])
        else $error("pad driven while off or input");
    AST_REQ_COUNT: assert property ($countones(requests) <= 2)
        else $error("more requests than pins");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> quiet <= DEBOUNCE_CYCLES + 16)
        else $error("irq with no recent cause");
    COV_WRITE: cover property (wr1);
    COV_IRQ: cover property ($rose(irq));
    COV_STATUS: cover property (ans && read && address[17:2] == IRQ_STATUS_IDX);
endmodule
bind gpio_pin_control pin_ctrl_monitor #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) mon (
    .clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .osc_32k(osc_32k), .sources(sources), .requests(requests)
);
`default_nettype wire

/* File: pin_pad_model.sv */
// Board side of the two pads: drivers, pulls and floating lines
`timescale 1ns/1ps
`default_nettype none
module pin_pad_model (
    // Clock
    input wire logic clock,
    // Device side
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    input wire logic [1:0] pull_up_en,
    input wire logic [1:0] pull_down_en,
    // Board drivers
    input wire logic [1:0] ext_en,
    input wire logic [1:0] ext_val,
    output logic [1:0] level
);
    logic [1:0] last = 2'h0;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!pin_oe_n[i]) begin
                level[i] = pin_out[i];
            end else if (ext_en[i]) begin
                level[i] = ext_val[i];
            end else if (pull_up_en[i] || pull_down_en[i]) begin
                level[i] = pull_up_en[i];
            end else begin
                // Floating: keep moving so no stale level passes
                level[i] = ~last[i];
            end
        end
    end
    always_ff @(posedge clock) begin
        last <= level;
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the two-pin control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pin_ctrl_pkg::*;
;
    localparam int DEB = 8;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [17:0] address = 18'h0_0000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] writedata = 32'h0000_0000;
    logic osc_32k = 1'b0;
    status_src_t sources = '0;
    logic [1:0] ext_en = 2'h0;
    logic [1:0] ext_val = 2'h0;
    logic [31:0] readdata;
    logic waitrequest, irq;
    logic [1:0] pin_in, pin_out, pin_oe_n, pull_up_en, pull_down_en;
    pin_requests_t requests;
    logic [15:0] rd;
    int fails = 0;
    int n_checks = 0;
    gpio_pin_control #(.DEBOUNCE_CYCLES(DEB)) dut (
        .clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .osc_32k(osc_32k), .sources(sources), .requests(requests)
    );
    pin_pad_model pad (
        .clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .ext_en(ext_en), .ext_val(ext_val), .level(pin_in)
    );
    initial begin
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Request held until the edge where waitrequest is seen low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wdat);
        @(posedge clock);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= {16'h0000, wdat};
        byteenable <= 4'hF;
        @(posedge clock);
        // No cycle count assumed; only the watchdog ends a hung wait
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        rd = readdata[15:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic print_verdict();
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        bus(1'b0, PIN1_CONTROL_IDX, 16'h0000);
        check("pin1 ctrl reset", rd, 16'hA400);
        bus(1'b0, PIN2_CONTROL_IDX, 16'h0000);
        check("pin2 ctrl reset", rd, 16'hA400);
        check("pads at reset", 16'({pull_up_en, pull_down_en, pin_oe_n}), 16'h000F);
        bus(1'b1, PIN2_CONTROL_IDX, 16'hFFFF);
        bus(1'b0, PIN2_CONTROL_IDX, 16'h0000);
        check("pin2 ctrl fields", rd, 16'hFE8F);
        bus(1'b1, PIN2_CONTROL_IDX, 16'hA400);
        bus(1'b0, 16'h4040, 16'h0000);
        check("unmapped read", rd, 16'h0000);
    endtask
    task automatic t_output();
        logic [15:0] ctl [6] = '{16'h4480, 16'h0480, 16'h0080, 16'h0680, 16'h0680, 16'h0400};
        logic [2:0] ex [6] = '{3'b110, 3'b000, 3'b100, 3'b101, 3'b000, 3'b101};
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, PIN1_CONTROL_IDX, ctl[i]);
            bus(1'b1, OUT_LEVEL_IDX, {15'h0000, ex[i][2]});
            cyc(3);
            check("pad drive", 16'({pin_out[0] & ~pin_oe_n[0], pin_oe_n[0]}), 16'(ex[i][1:0]));
        end
        bus(1'b0, OUT_LEVEL_IDX, 16'h0000);
        check("out level reg", rd, 16'h0001);
    endtask
    task automatic t_outcodes();
        int t;
        logic p;
        for (int c = 1; c < 16; c++) begin
            if (c == 14) continue;
            for (int l = 0; l < 2; l++) begin
                @(posedge clock);
                sources <= {10{l[0]}};
                osc_32k <= l[0];
                bus(1'b1, PIN1_CONTROL_IDX, 16'h0480 | 16'(c));
                cyc(6);
                check("source out", 16'(pin_out[0]), (c > 4 && c < 8) ? 16'h0000 : 16'(l));
            end
        end
        bus(1'b1, PIN1_CONTROL_IDX, 16'h048E);
        cyc(3);
        t = 0;
        for (int i = 0; i < 100; i++) begin
            p = pin_out[0];
            cyc(1);
            if (pin_out[0] !== p) t++;
        end
        check("clock toggles", 16'(t), 16'h0004);
    endtask
    task automatic t_irq();
        logic [3:0] ex [4] = '{4'b0110, 4'b0001, 4'b1111, 4'b1011};
        bus(1'b1, IRQ_MASK_IDX, 16'h0003);
        @(posedge clock);
        ext_en <= 2'b01;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, PIN1_CONTROL_IDX, {3'b100, ex[i][3], 1'b0, ex[i][2], 10'h081});
            cyc(20);
            bus(1'b0, IRQ_STATUS_IDX, 16'h0000);
            for (int e = 0; e < 2; e++) begin
                @(posedge clock);
                ext_val <= {1'b0, e == 0};
                cyc(20);
                check("irq on edge", 16'(irq), 16'(ex[i][1 - e]));
                bus(1'b0, IRQ_STATUS_IDX, 16'h0000);
                check("status", rd, 16'(ex[i][1 - e]));
                cyc(3);
                check("irq cleared", 16'(irq), 16'h0000);
            end
        end
        bus(1'b1, IRQ_MASK_IDX, 16'h0000);
        @(posedge clock);
        ext_val <= 2'b01;
        cyc(20);
        check("masked irq", 16'(irq), 16'h0000);
        bus(1'b0, IRQ_STATUS_IDX, 16'h0000);
        check("masked status", rd, 16'h0001);
        @(posedge clock);
        ext_val <= 2'b00;
    endtask
    task automatic t_req();
        logic [10:0] rq [16] = '{11'h000, 11'h000, 11'h400, 11'h200, 11'h200, 11'h100, 11'h080,
            11'h040, 11'h020, 11'h010, 11'h004, 11'h008, 11'h001, 11'h002, 11'h001, 11'h002};
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, PIN1_CONTROL_IDX, 16'h8480 | 16'(c));
            @(posedge clock);
            ext_val <= 2'b01;
            cyc(30);
            check("request on", 16'(requests), 16'(rq[c]));
            bus(1'b0, PIN_LEVEL_IDX, 16'h0000);
            check("pin level", rd, 16'h0001);
            @(posedge clock);
            ext_val <= 2'b00;
            cyc(30);
            check("request off", 16'(requests), 16'h0000);
        end
        // Pulse shorter than the debounce must not reach the request
        @(posedge clock);
        ext_val <= 2'b01;
        repeat (3) @(posedge clock);
        ext_val <= 2'b00;
        cyc(30);
        check("short pulse", 16'(requests), 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_regs();
        t_output();
        t_outcodes();
        t_irq();
        t_req();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
